/* rtl/fsfwe_pkg.sv */
// shared constants, types and helpers of the width-expandable fifo pair
package fsfwe_pkg;
   // ------------------------------------------------------------------
   // fifo geometry
   // ------------------------------------------------------------------
   localparam int WORD_W = 9;
   localparam int DEF_DEPTH = 16384;
   localparam int DEF_SLICES = 2;
   localparam int OFFSET_REGS = 4;
   localparam int OFFSET_W = 2 * WORD_W;
   localparam logic [WORD_W-1:0] DEF_OFFSET_LO = 9'h007;
   localparam logic [WORD_W-1:0] DEF_OFFSET_HI = 9'h000;

   // offset register sequence, one step per load access
   typedef enum logic [1:0] {
      OFS_EMPTY_LO = 2'b00,
      OFS_EMPTY_HI = 2'b01,
      OFS_FULL_LO = 2'b10,
      OFS_FULL_HI = 2'b11
   } fsfwe_ofs_t;

   // ------------------------------------------------------------------
   // controller register map (apb, byte addresses)
   // ------------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TXDATA = 8'h08;
   localparam logic [7:0] REG_RXDATA = 8'h0c;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h14;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h18;
   localparam int CTRL_LOAD_BIT = 0;
   localparam int ST_FULL = 0;
   localparam int ST_EMPTY = 1;
   localparam int ST_AEMPTY = 2;
   localparam int ST_AFULL = 3;
   localparam int ST_BUSY = 4;
   localparam int IRQ_W = 4;
   localparam int IRQ_WR_REFUSED = 0;
   localparam int IRQ_RD_REFUSED = 1;
   localparam int IRQ_RD_DONE = 2;
   localparam int IRQ_AFULL = 3;
   // cycles from read strobe until the word is captured
   localparam int RD_PIPE_LEN = 2;

   // next register of the offset sequence, wrapping after the last
   function automatic fsfwe_ofs_t next_ofs(input fsfwe_ofs_t cur);
      case (cur)
         OFS_EMPTY_LO: next_ofs = OFS_EMPTY_HI;
         OFS_EMPTY_HI: next_ofs = OFS_FULL_LO;
         OFS_FULL_LO: next_ofs = OFS_FULL_HI;
         default: next_ofs = OFS_EMPTY_LO;
      endcase
   endfunction

   // threshold formed from a high and a low offset register
   function automatic logic [OFFSET_W-1:0] offset_value(
      input logic [WORD_W-1:0] hi,
      input logic [WORD_W-1:0] lo);
      offset_value = {hi, lo};
   endfunction
endpackage

/* rtl/fsfwe_link_if.sv */
// pin bundle shared by the host logic and all fifo slices
`timescale 1ns/10ps
interface fsfwe_link_if #(
   parameter int SLICES = 2
);
   // shared controls, one set for every slice
   logic write_enable_primary_n;
   logic write_enable_secondary_or_load;
   logic read_enable_primary_n;
   logic read_enable_secondary_n;
   logic [SLICES*9-1:0] write_data;
   // per-slice outputs, each slice drives its own bits
   wire [SLICES*9-1:0] read_data;
   wire [SLICES-1:0] full_indicator_n;
   wire [SLICES-1:0] empty_indicator_n;
   wire [SLICES-1:0] almost_empty_indicator_n;
   wire [SLICES-1:0] almost_full_indicator_n;

   modport device (
      input write_enable_primary_n,
      input write_enable_secondary_or_load,
      input read_enable_primary_n,
      input read_enable_secondary_n,
      input write_data,
      output read_data,
      output full_indicator_n,
      output empty_indicator_n,
      output almost_empty_indicator_n,
      output almost_full_indicator_n
   );

   modport host (
      output write_enable_primary_n,
      output write_enable_secondary_or_load,
      output read_enable_primary_n,
      output read_enable_secondary_n,
      output write_data,
      input read_data,
      input full_indicator_n,
      input empty_indicator_n,
      input almost_empty_indicator_n,
      input almost_full_indicator_n
   );
endinterface // fsfwe_link_if

/* rtl/fsfwe_fifo_slice.sv */
// one 9-bit fifo slice with full, empty and programmable flags
`timescale 1ns/10ps
module fsfwe_fifo_slice
   import fsfwe_pkg::*;
#(
   parameter int DEPTH = DEF_DEPTH,
   parameter int SLICES = DEF_SLICES,
   parameter int SLICE = 0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // pins towards the host logic
   fsfwe_link_if.device link,
   // user side status
   output logic load_mode,
   output logic [$clog2(DEPTH):0] fill_level
);
   // ------------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------------
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   // pointers wrap naturally only on a power of two depth
   if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0 ||
       CW > OFFSET_W) begin : g_bad_depth
      $error("fsfwe_fifo_slice: DEPTH must be a power of two, 16..131072");
   end
   if (SLICE < 0 || SLICE >= SLICES) begin : g_bad_slice
      $error("fsfwe_fifo_slice: SLICE outside 0..SLICES-1");
   end

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [CW-1:0] count;
      logic full_n;
      logic empty_n;
      logic ae_n;
      logic af_n;
      logic [WORD_W-1:0] rd_q;
      logic load_mode;
      logic strap_pending;
      fsfwe_ofs_t wsel;
      fsfwe_ofs_t rsel;
      logic [OFFSET_REGS-1:0][WORD_W-1:0] offs;
   } fsfwe_slice_state_t;

   // offsets come up as n = m = 7, flags as for an empty fifo
   localparam fsfwe_slice_state_t ST_RST = '{
      wptr: '0,
      rptr: '0,
      count: '0,
      full_n: 1'b1,
      empty_n: 1'b0,
      ae_n: 1'b0,
      af_n: 1'b1,
      rd_q: '0,
      load_mode: 1'b0,
      strap_pending: 1'b1,
      wsel: OFS_EMPTY_LO,
      rsel: OFS_EMPTY_LO,
      offs: {DEF_OFFSET_HI, DEF_OFFSET_LO, DEF_OFFSET_HI, DEF_OFFSET_LO}
   };

   fsfwe_slice_state_t st;
   fsfwe_slice_state_t next_st;

   logic [WORD_W-1:0] mem [DEPTH];
   logic [WORD_W-1:0] slice_in;
   logic [WORD_W-1:0] mem_word;
   logic wr_fire;
   logic rd_fire;
   logic ofs_wr;
   logic ofs_rd;
   logic ld_pin;
   logic [OFFSET_W-1:0] n_val;
   logic [OFFSET_W-1:0] m_val;
   logic [31:0] used;
   logic [31:0] free;

   // this slice's share of the wide word
   assign slice_in = link.write_data[SLICE*WORD_W +: WORD_W];
   assign ld_pin = link.write_enable_secondary_or_load;
   assign mem_word = mem[st.rptr];

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      next_st = st;
      // dual-purpose pin sampled at the first edge after reset release
      if (st.strap_pending) begin
         next_st.load_mode = ~ld_pin;
         next_st.strap_pending = 1'b0;
      end

      // offset access while the pin acts as load and is low
      ofs_wr = !st.strap_pending && st.load_mode && !ld_pin &&
               !link.write_enable_primary_n;
      ofs_rd = !st.strap_pending && st.load_mode && !ld_pin &&
               !link.read_enable_primary_n &&
               !link.read_enable_secondary_n;

      // pin high means data write in either mode
      wr_fire = !st.strap_pending && st.full_n && ld_pin &&
                !link.write_enable_primary_n;
      rd_fire = !st.strap_pending && st.empty_n &&
                !link.read_enable_primary_n &&
                !link.read_enable_secondary_n &&
                !(st.load_mode && !ld_pin);

      // pointers and fill count
      if (wr_fire) begin
         next_st.wptr = st.wptr + AW'(1);
      end
      if (rd_fire) begin
         next_st.rptr = st.rptr + AW'(1);
         next_st.rd_q = mem_word;
      end
      next_st.count = st.count + CW'(wr_fire) - CW'(rd_fire);

      // offset registers walk their own sequence for writes and reads
      if (ofs_wr) begin
         next_st.offs[st.wsel] = slice_in;
         next_st.wsel = next_ofs(st.wsel);
      end
      if (ofs_rd) begin
         next_st.rd_q = st.offs[st.rsel];
         next_st.rsel = next_ofs(st.rsel);
      end

      // thresholds from the updated offset registers
      n_val = offset_value(next_st.offs[OFS_EMPTY_HI],
                           next_st.offs[OFS_EMPTY_LO]);
      m_val = offset_value(next_st.offs[OFS_FULL_HI],
                           next_st.offs[OFS_FULL_LO]);
      used = 32'(next_st.count);
      free = 32'(DEPTH) - used;

      // single clock: both flag groups see the same count
      next_st.full_n = (used != 32'(DEPTH));
      next_st.empty_n = (used != 32'h0000_0000);
      next_st.ae_n = (used > 32'(n_val));
      next_st.af_n = (free > 32'(m_val));
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // state register, flags move only on the clock edge or at asynchronous reset
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   // storage array, written only when not full
   always_ff @(posedge sys_clk) begin
      if (wr_fire) begin
         mem[st.wptr] <= slice_in;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   // every pin straight from the state register
   assign link.read_data[SLICE*WORD_W +: WORD_W] = st.rd_q;
   assign link.full_indicator_n[SLICE] = st.full_n;
   assign link.empty_indicator_n[SLICE] = st.empty_n;
   assign link.almost_empty_indicator_n[SLICE] = st.ae_n;
   assign link.almost_full_indicator_n[SLICE] = st.af_n;
   assign load_mode = st.load_mode;
   assign fill_level = st.count;
endmodule // fsfwe_fifo_slice

/* rtl/fsfwe_host_ctrl.sv */
// apb controlled host logic driving a width-expanded fifo bank
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module fsfwe_host_ctrl
   import fsfwe_pkg::*;
#(
   parameter int SLICES = DEF_SLICES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // apb slave
   input wire logic [APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq,
   // pins towards the fifo bank
   fsfwe_link_if.host link
);
   localparam int DW = SLICES * WORD_W;

   if (SLICES < 1 || DW > 32) begin : g_bad_slices
      $error("fsfwe_host_ctrl: SLICES*9 must fit in 32 bits");
   end

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic load_access;
      logic strap_hold;
      logic wen_n;
      logic ld;
      logic ren_n;
      logic [DW-1:0] wdata;
      logic [RD_PIPE_LEN-1:0] rd_pipe;
      logic [DW-1:0] rx_word;
      logic af_prev;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
   } fsfwe_host_state_t;

   fsfwe_host_state_t st;
   fsfwe_host_state_t next_st;

   logic full_any;
   logic empty_any;
   logic ae_one;
   logic af_one;
   logic acc_wr;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] clr;
   logic [31:0] rd_mux;
   logic mapped;

   // combined end-point flags, partial flags from slice zero
   assign full_any = ~&link.full_indicator_n;
   assign empty_any = ~&link.empty_indicator_n;
   assign ae_one = ~link.almost_empty_indicator_n[0];
   assign af_one = ~link.almost_full_indicator_n[0];

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      next_st = st;
      ev = '0;
      clr = '0;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.wen_n = 1'b1;
      next_st.ren_n = 1'b1;

      // read mux, sampled in the setup cycle
      mapped = 1'b1;
      case (paddr)
         REG_CTRL: rd_mux = 32'(st.load_access);
         REG_STATUS: rd_mux = 32'({|st.rd_pipe, af_one, ae_one,
                                   empty_any, full_any});
         REG_TXDATA: rd_mux = 32'(st.wdata);
         REG_RXDATA: rd_mux = 32'(st.rx_word);
         REG_IRQ_STATUS: rd_mux = 32'(st.irq_stat);
         REG_IRQ_CLEAR: rd_mux = 32'h0000_0000;
         REG_IRQ_ENABLE: rd_mux = 32'(st.irq_en);
         default: begin
            rd_mux = 32'h0000_0000;
            mapped = 1'b0;
         end
      endcase

      // answer one cycle after setup
      if (psel && !penable) begin
         next_st.pready = 1'b1;
         next_st.pslverr = !mapped;
         next_st.prdata = pwrite ? 32'h0000_0000 : rd_mux;
      end

      // writes take effect at the completing edge
      acc_wr = psel && penable && st.pready && pwrite && mapped;
      if (acc_wr) begin
         case (paddr)
            REG_CTRL: next_st.load_access = pwdata[CTRL_LOAD_BIT];
            REG_TXDATA: begin
               if (!st.load_access && full_any) begin
                  ev[IRQ_WR_REFUSED] = 1'b1;
               end else begin
                  next_st.wen_n = 1'b0;
                  next_st.wdata = pwdata[DW-1:0];
               end
            end
            REG_RXDATA: begin
               if (!st.load_access && empty_any) begin
                  ev[IRQ_RD_REFUSED] = 1'b1;
               end else begin
                  next_st.ren_n = 1'b0;
               end
            end
            REG_IRQ_CLEAR: clr = pwdata[IRQ_W-1:0];
            REG_IRQ_ENABLE: next_st.irq_en = pwdata[IRQ_W-1:0];
            default: next_st.irq_en = st.irq_en;
         endcase
      end

      // load pin held low through reset and the strap edge
      next_st.strap_hold = 1'b0;
      next_st.ld = st.strap_hold ? 1'b0 : !next_st.load_access;

      // capture the read word once it stands on the pins
      next_st.rd_pipe = {st.rd_pipe[RD_PIPE_LEN-2:0], !st.ren_n};
      if (st.rd_pipe[RD_PIPE_LEN-2]) begin
         next_st.rx_word = link.read_data;
         ev[IRQ_RD_DONE] = 1'b1;
      end

      // almost-full entry event
      next_st.af_prev = af_one;
      ev[IRQ_AFULL] = af_one && !st.af_prev;

      // sticky status, a new event beats a clear
      next_st.irq_stat = (st.irq_stat & ~clr) | ev;
      next_st.irq = |(next_st.irq_stat & next_st.irq_en);
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{strap_hold: 1'b1, wen_n: 1'b1, ren_n: 1'b1,
                 default: '0};
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign irq = st.irq;
   assign link.write_enable_primary_n = st.wen_n;
   assign link.write_enable_secondary_or_load = st.ld;
   assign link.read_enable_primary_n = st.ren_n;
   assign link.read_enable_secondary_n = 1'b0;
   assign link.write_data = st.wdata;
endmodule // fsfwe_host_ctrl

/* verification/fsfwe_link_checker.sv */
// assertions on the pins between the host logic and the fifo slices
`timescale 1ns/10ps
module fsfwe_link_checker #(
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // shared controls
   input wire logic write_enable_primary_n,
   input wire logic write_enable_secondary_or_load,
   input wire logic read_enable_primary_n,
   input wire logic read_enable_secondary_n,
   // per-slice outputs
   input wire logic [17:0] read_data,
   input wire logic [1:0] full_indicator_n,
   input wire logic [1:0] empty_indicator_n,
   input wire logic [1:0] almost_empty_indicator_n,
   input wire logic [1:0] almost_full_indicator_n
);
   // -------------------------------------------------------------------
   // word count rebuilt from accepted strobes
   // -------------------------------------------------------------------
   logic wr_ok;
   logic rd_ok;
   logic [5:0] cnt;

   // a strobe counts only when the flags let it through
   assign wr_ok = !write_enable_primary_n && write_enable_secondary_or_load
      && full_indicator_n[0];
   assign rd_ok = !read_enable_primary_n && !read_enable_secondary_n
      && write_enable_secondary_or_load && empty_indicator_n[0];

   // count register, cleared by reset only
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 6'h00;
      end else begin
         cnt <= cnt + 6'(wr_ok) - 6'(rd_ok);
      end
   end

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   full_level_a: assert property (
      full_indicator_n[0] == (cnt != DEPTH))
      else $error("full flag does not match word count");
   empty_level_a: assert property (
      empty_indicator_n[0] == (cnt != 0))
      else $error("empty flag does not match word count");
   almost_empty_a: assert property (
      almost_empty_indicator_n[0] == (cnt > 7))
      else $error("almost-empty flag wrong for count");
   almost_full_a: assert property (
      almost_full_indicator_n[0] == ((DEPTH - cnt) > 7))
      else $error("almost-full flag wrong for count");
   full_refuse_a: assert property (
      (!full_indicator_n[0] && !write_enable_primary_n
         && read_enable_primary_n) |=> !full_indicator_n[0])
      else $error("write accepted while full");
   empty_refuse_a: assert property (
      (!empty_indicator_n[0] && !read_enable_primary_n
         && write_enable_primary_n && write_enable_secondary_or_load)
      |=> !empty_indicator_n[0] && $stable(read_data))
      else $error("read accepted while empty");
   full_release_a: assert property (
      $rose(full_indicator_n[0]) |-> !$past(read_enable_primary_n))
      else $error("full flag left without a read");
   empty_release_a: assert property (
      $rose(empty_indicator_n[0]) |-> !$past(write_enable_primary_n))
      else $error("empty flag left without a write");
   slice_agree_a: assert property (
      full_indicator_n[0] == full_indicator_n[1]
      && empty_indicator_n[0] == empty_indicator_n[1]
      && almost_full_indicator_n[0] == almost_full_indicator_n[1])
      else $error("slices disagree on flags");
   second_read_a: assert property (
      read_enable_secondary_n == 1'b0)
      else $error("secondary read enable not tied low");
endmodule // fsfwe_link_checker

/* verification/fifo_status_flags_width_expansion_tb_top.sv */
// self-checking bench for the host logic and two fifo slices
`timescale 1ns/10ps
module fifo_status_flags_width_expansion_tb_top;
   import fsfwe_pkg::*;
   localparam int DEPTH = 16;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   wire [1:0] load_mode;
   wire [4:0] fill_level [2];
   logic [31:0] rd;
   logic err;
   logic [17:0] fifo_q [$];
   logic [17:0] last_word = 18'h0;
   logic [17:0] ofs_val [4];
   int n_mismatch = 0;
   int check_count = 0;
   int seed = 32'h1902;
   int cnt = 0;

   // 100 mhz clock
   always #5 sys_clk = ~sys_clk;

   // -------------------------------------------------------------------
   // design and checker
   // -------------------------------------------------------------------
   fsfwe_link_if #(.SLICES(2)) link ();
   fsfwe_host_ctrl #(.SLICES(2)) fsfwe_host_ctrl_i (.sys_clk(sys_clk),
      .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .link(link));
   for (genvar k = 0; k < 2; k++) begin : g_slice
      fsfwe_fifo_slice #(.DEPTH(DEPTH), .SLICES(2), .SLICE(k))
         fsfwe_fifo_slice_i (.sys_clk(sys_clk), .arst_n(arst_n),
         .link(link), .load_mode(load_mode[k]),
         .fill_level(fill_level[k]));
   end
   fsfwe_link_checker #(.DEPTH(DEPTH)) fsfwe_link_checker_i (
      .sys_clk(sys_clk), .arst_n(arst_n),
      .write_enable_primary_n(link.write_enable_primary_n),
      .write_enable_secondary_or_load(link.write_enable_secondary_or_load),
      .read_enable_primary_n(link.read_enable_primary_n),
      .read_enable_secondary_n(link.read_enable_secondary_n),
      .read_data(link.read_data), .full_indicator_n(link.full_indicator_n),
      .empty_indicator_n(link.empty_indicator_n),
      .almost_empty_indicator_n(link.almost_empty_indicator_n),
      .almost_full_indicator_n(link.almost_full_indicator_n));

   // -------------------------------------------------------------------
   // tasks and expectations
   // -------------------------------------------------------------------
   task automatic final_report();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_mismatch++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // expected status word for a given fill count
   function automatic logic [31:0] exp_status(input int c);
      return {28'h0, 1'(DEPTH - c <= 7), 1'(c <= 7), 1'(c == 0),
         1'(c == DEPTH)};
   endfunction

   // write one word, model it, check flags and fill level
   task automatic push(input logic [17:0] d);
      apb(1'b1, REG_TXDATA, {14'h0, d});
      repeat (2) @(posedge sys_clk);
      if (cnt < DEPTH) begin
         fifo_q.push_back(d);
         cnt++;
      end
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd, exp_status(cnt));
      check(32'(fill_level[1]), 32'(cnt));
      check(32'(fill_level[0]), 32'(cnt));
   endtask

   // read one offset register of every slice through the capture pipe
   task automatic ofs_read(input logic [17:0] e);
      apb(1'b1, REG_RXDATA, 32'h0);
      repeat (4) @(posedge sys_clk);
      apb(1'b0, REG_RXDATA, 32'h0);
      check(rd, {14'h0, e});
   endtask

   // read one word through the capture pipe and compare it
   task automatic pop();
      apb(1'b1, REG_RXDATA, 32'h0);
      repeat (4) @(posedge sys_clk);
      if (cnt > 0) begin
         last_word = fifo_q.pop_front();
         cnt--;
      end
      apb(1'b0, REG_RXDATA, 32'h0);
      check(rd, {14'h0, last_word});
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd, exp_status(cnt));
   endtask

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check(32'(load_mode), 32'h3);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd, exp_status(0));
      // offset registers: defaults, a random set, defaults again
      apb(1'b1, REG_CTRL, 32'h1);
      for (int i = 0; i < 4; i++) begin
         ofs_val[i] = i[0] ? {DEF_OFFSET_HI, DEF_OFFSET_HI} :
            {DEF_OFFSET_LO, DEF_OFFSET_LO};
         ofs_read(ofs_val[i]);
      end
      for (int i = 0; i < 4; i++) begin
         ofs_val[i] = (i == 3) ? 18'h0 : 18'($random(seed));
         if (i == 2) begin
            ofs_val[i] = ofs_val[i] & 18'h01e0f; // m stays below depth
         end
         apb(1'b1, REG_TXDATA, {14'h0, ofs_val[i]});
      end
      for (int i = 0; i < 4; i++) begin
         ofs_read(ofs_val[i]);
      end
      for (int i = 0; i < 4; i++) begin
         ofs_val[i] = i[0] ? {DEF_OFFSET_HI, DEF_OFFSET_HI} :
            {DEF_OFFSET_LO, DEF_OFFSET_LO};
         apb(1'b1, REG_TXDATA, {14'h0, ofs_val[i]});
      end
      apb(1'b1, REG_CTRL, 32'h0);
      apb(1'b1, REG_IRQ_CLEAR, 32'hf);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd, exp_status(0));
      $display("test offsets done");
      apb(1'b1, REG_IRQ_ENABLE, 32'h1);
      $display("test reset done");
      // fill to full, then one refused write
      for (int i = 0; i < DEPTH; i++) begin
         push(18'($random(seed)));
      end
      apb(1'b0, REG_IRQ_STATUS, 32'h0);
      check(rd, 32'h8);
      check(32'(irq), 32'h0);
      push(18'h3ffff);
      repeat (2) @(posedge sys_clk);
      apb(1'b0, REG_IRQ_STATUS, 32'h0);
      check(rd, 32'h9);
      check(32'(irq), 32'h1);
      apb(1'b1, REG_IRQ_CLEAR, 32'hf);
      repeat (2) @(posedge sys_clk);
      check(32'(irq), 32'h0);
      $display("test fill done");
      // drain to empty, then one refused read
      for (int i = 0; i <= DEPTH; i++) begin
         pop();
      end
      apb(1'b0, REG_IRQ_STATUS, 32'h0);
      check(rd, 32'h6);
      apb(1'b0, 8'h1c, 32'h0);
      check(rd, 32'h0);
      check(32'(err), 32'h1);
      $display("test drain done");
      // random mix of writes and reads
      for (int i = 0; i < 60; i++) begin
         if ($random(seed) & 1) begin
            push(18'($random(seed)));
         end else begin
            pop();
         end
      end
      $display("test random done");
      final_report();
   end
endmodule // fifo_status_flags_width_expansion_tb_top
